// >>> voice_audio_pkg.sv
`default_nettype none
package voice_audio_pkg;
   localparam int unsigned SYS_CLK_HZ = 125000000;
   localparam int unsigned AUDIO_MCLK_HZ = 12288000;
   localparam int unsigned MICROPHONE_CLOCK_OUT_HZ = 3072000;
   localparam int unsigned BCLK48_HZ = 3072000;
   localparam int unsigned BCLK16_HZ = 1024000;
   localparam int unsigned RATE48_HZ = 48000;
   localparam int unsigned RATE16_HZ = 16000;
   localparam int unsigned USB_REF_HZ = 1000;
   localparam int SLOT_BITS = 32;
   localparam int FRAME_BITS = 2 * SLOT_BITS;
   // Audio clock edges per half period of each derived clock
   localparam logic [1:0] MIC_HALF = 2'(AUDIO_MCLK_HZ / MICROPHONE_CLOCK_OUT_HZ / 2);
   localparam logic [2:0] BCLK48_HALF = 3'(AUDIO_MCLK_HZ / BCLK48_HZ / 2);
   localparam logic [2:0] BCLK16_HALF = 3'(AUDIO_MCLK_HZ / BCLK16_HZ / 2);
   // Audio clock rising edges expected between two reference events
   localparam logic [15:0] REF_TICKS_48K = 16'(AUDIO_MCLK_HZ / RATE48_HZ);
   localparam logic [15:0] REF_TICKS_16K = 16'(AUDIO_MCLK_HZ / RATE16_HZ);
   localparam logic [15:0] REF_TICKS_USB = 16'(AUDIO_MCLK_HZ / USB_REF_HZ);
   // Phase step per system clock; one carry is one half period of the audio clock
   localparam logic [31:0] NCO_NOMINAL =
      32'((64'(2) * 64'(AUDIO_MCLK_HZ) << 32) / 64'(SYS_CLK_HZ));
   localparam logic [31:0] NCO_TRIM_STEP = 32'h0000_1000;
   // Bit positions of the shared two-way pins
   localparam int PIN_AMCLK = 0;
   localparam int PIN_BCLK = 1;
   localparam int PIN_FSC = 2;
   localparam int PIN_L0 = 3;
   localparam int PIN_L1 = 4;
   localparam int PIN_COUNT = 5;
endpackage : voice_audio_pkg
`default_nettype wire

// >>> voice_audio_link_if.sv
`default_nettype none
interface voice_audio_link_if;
   // Two-way pins: audio clock, bit clock, frame select clock, lines 0 and 1
   logic [4:0] devO;
   logic [4:0] devOeN;
   logic [4:0] hostO;
   logic [4:0] hostOeN;
   logic [4:0] pin;
   // One-way pins
   logic serialAudioLine2;
   logic microphoneClockOut;
   logic [3:0] microphonePdmInputs;
   // Undriven pins read low, as with a weak pull-down
   assign pin = (~devOeN & devO) | (~hostOeN & hostO);
   modport device (
      output devO, devOeN, serialAudioLine2, microphoneClockOut,
      input pin, microphonePdmInputs
   );
   modport host (
      output hostO, hostOeN, microphonePdmInputs,
      input pin, serialAudioLine2, microphoneClockOut
   );
endinterface : voice_audio_link_if
`default_nettype wire

// >>> voice_audio_host.sv
`default_nettype none
module voice_audio_host (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Configuration
   input wire logic usbAttachedConfig,
   input wire logic rate48k,
   input wire logic driveMasterClock,
   input wire logic sendReference,
   // Words to send
   input wire logic [31:0] txData,
   input wire logic txValid,
   output logic txReady,
   // Words received
   output logic [31:0] rxData,
   output logic rxRight,
   output logic rxValid,
   // Microphone model
   input wire logic [3:0] micBits,
   // Link
   voice_audio_link_if.host link
);
   typedef struct packed {
      logic [4:0] syncA;
      logic [4:0] syncB;
      logic micA;
      logic micB;
      logic micPrev;
      logic [3:0] micO;
      logic [31:0] nco;
      logic am;
      logic [2:0] div;
      logic bclkGen;
      logic lrGen;
      logic [5:0] genCnt;
      logic bcPrev;
      logic lrLast;
      logic [4:0] pos;
      logic [31:0] txShift;
      logic [31:0] txHold;
      logic txRdy;
      logic [31:0] rxShift;
      logic [31:0] rxData;
      logic rxRight;
      logic rxValid;
      logic [4:0] pinO;
      logic [4:0] pinOeN;
   } hstate_t;

   localparam hstate_t H_RESET = '{txRdy: 1'b1, pinOeN: 5'h1F, default: '0};
   hstate_t s;
   hstate_t next_s;

   always_comb begin
      logic carry;
      logic amRise;
      logic bc;
      logic lr;
      logic din;
      logic [2:0] half;
      carry = 1'b0;
      amRise = 1'b0;
      bc = 1'b0;
      lr = 1'b0;
      din = 1'b0;
      half = rate48k ? voice_audio_pkg::BCLK48_HALF : voice_audio_pkg::BCLK16_HALF;
      next_s = s;
      next_s.syncA = link.pin;
      next_s.syncB = s.syncA;
      next_s.micA = link.microphoneClockOut;
      next_s.micB = s.micA;
      next_s.micPrev = s.micB;
      next_s.rxValid = 1'b0;
      // Own audio clock; the bit clock is divided from it, so both stay locked
      {carry, next_s.nco} = {1'b0, s.nco} + {1'b0, voice_audio_pkg::NCO_NOMINAL}; // [RULE_11]
      if (carry) begin
         next_s.am = !s.am;
      end
      amRise = carry && !s.am;
      if (amRise) begin
         if (s.div >= half - 3'h1) begin // [RULE_02]
            next_s.div = 3'h0;
            next_s.bclkGen = !s.bclkGen;
            if (s.bclkGen) begin
               next_s.genCnt = (s.genCnt == 6'(voice_audio_pkg::FRAME_BITS - 1)) ?
                  6'h00 : s.genCnt + 6'h01;
               next_s.lrGen = (next_s.genCnt >= 6'(voice_audio_pkg::SLOT_BITS)); // [RULE_03]
            end
         end else begin
            next_s.div = s.div + 3'h1;
         end
      end
      // Microphones change data on the falling edge of the device clock
      if (!s.micB && s.micPrev) begin
         next_s.micO = micBits; // [RULE_13]
      end
      bc = usbAttachedConfig ? s.syncB[voice_audio_pkg::PIN_BCLK] : s.bclkGen;
      lr = usbAttachedConfig ? s.syncB[voice_audio_pkg::PIN_FSC] : s.lrGen;
      din = usbAttachedConfig ? s.syncB[voice_audio_pkg::PIN_L0] :
         s.syncB[voice_audio_pkg::PIN_L1];
      next_s.bcPrev = bc;
      if (bc && !s.bcPrev) begin
         next_s.rxShift = {s.rxShift[30:0], din};
         if (lr != s.lrLast) begin // [RULE_05]
            next_s.rxData = next_s.rxShift;
            next_s.rxRight = s.lrLast;
            next_s.rxValid = 1'b1;
            next_s.lrLast = lr;
            next_s.pos = 5'h00;
         end else begin
            next_s.pos = (s.pos == 5'(voice_audio_pkg::SLOT_BITS - 1)) ? 5'h00 : s.pos + 5'h01;
         end
      end
      if (!bc && s.bcPrev) begin
         if (s.pos == 5'h00) begin // [RULE_04]
            next_s.txShift = s.txRdy ? 32'h0000_0000 : s.txHold;
            next_s.txRdy = 1'b1;
         end else begin
            next_s.txShift = {s.txShift[30:0], 1'b0};
         end
      end
      if (s.txRdy && txValid) begin
         next_s.txHold = txData;
         next_s.txRdy = 1'b0;
      end
      next_s.pinO = {next_s.txShift[31], next_s.txShift[31], next_s.lrGen, next_s.bclkGen,
         next_s.am};
      next_s.pinOeN[voice_audio_pkg::PIN_AMCLK] = usbAttachedConfig || !driveMasterClock;
      next_s.pinOeN[voice_audio_pkg::PIN_BCLK] = usbAttachedConfig;
      next_s.pinOeN[voice_audio_pkg::PIN_FSC] = usbAttachedConfig;
      next_s.pinOeN[voice_audio_pkg::PIN_L0] = usbAttachedConfig;
      next_s.pinOeN[voice_audio_pkg::PIN_L1] = !(usbAttachedConfig && sendReference);
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         s <= H_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign txReady = s.txRdy;
   assign rxData = s.rxData;
   assign rxRight = s.rxRight;
   assign rxValid = s.rxValid;
   assign link.hostO = s.pinO;
   assign link.hostOeN = s.pinOeN;
   assign link.microphonePdmInputs = s.micO;
endmodule : voice_audio_host
`default_nettype wire

// >>> voice_audio_device.sv
// Behaviour
// RULE_01: Host-attached: slave, one shared clock set
// RULE_02: Bit clock 1.024 or 3.072 MHz
// RULE_03: Frame clock is bit clock over 64
// RULE_04: Each channel slot is 32 bit clocks
// RULE_05: MSB first, one bit after frame edge
// RULE_06: Host-attached: line0 in, line1/line2 out
// RULE_07: USB-attached: master, clocks out, line0 out
// RULE_08: USB-attached: line1 optional reference input
// RULE_09: Internal audio clock locked, driven on pin
// RULE_10: USB-attached: internal clock, stream reference
// RULE_11: External clock from host, locked to link
// RULE_12: Drive 3.072 MHz microphone clock
// RULE_13: Microphones clock data on microphone clock
// RULE_14: USB-attached: audio clock tracks host stream
// RULE_15: No stream: nominal 12.288 MHz audio clock
// RULE_16: Microphone clock is audio clock over four
`default_nettype none
module voice_audio_device (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Configuration
   input wire logic usbAttachedConfig,
   input wire logic externalClockMode,
   input wire logic rate48k,
   // USB stream reference
   input wire logic usbStreamActive,
   input wire logic usbRefTick,
   // Processed audio to send
   input wire logic [31:0] txData,
   input wire logic txValid,
   output logic txReady,
   // Reference audio received
   output logic [31:0] rxData,
   output logic rxRight,
   output logic rxValid,
   input wire logic rxReady,
   output logic rxOverrun,
   // Microphone samples
   output logic [3:0] micSample,
   output logic micStrobe,
   // Link
   voice_audio_link_if.device link
);
   typedef struct packed {
      logic [4:0] syncA;
      logic [4:0] syncB;
      logic [3:0] micA;
      logic [3:0] micB;
      logic [31:0] nco;
      logic [31:0] ncoInc;
      logic amInt;
      logic amPrev;
      logic [15:0] refCnt;
      logic [1:0] micDiv;
      logic micClk;
      logic [2:0] bclkDiv;
      logic bclkGen;
      logic lrGen;
      logic [5:0] genCnt;
      logic bcPrev;
      logic lrLast;
      logic [4:0] pos;
      logic [31:0] txShift;
      logic [31:0] txHold;
      logic txRdy;
      logic [31:0] rxShift;
      logic [31:0] fwdWord;
      logic [31:0] fwdShift;
      logic headV;
      logic [32:0] head;
      logic spareV;
      logic [32:0] spare;
      logic overrun;
      logic [3:0] micSample;
      logic micStrobe;
      logic [4:0] pinO;
      logic [4:0] pinOeN;
      logic line2;
   } dstate_t;

   localparam dstate_t D_RESET = '{
      ncoInc: voice_audio_pkg::NCO_NOMINAL,
      txRdy: 1'b1,
      pinOeN: 5'h1F,
      default: '0
   };
   dstate_t s;
   dstate_t next_s;

   always_comb begin
      logic usb;
      logic ext;
      logic carry;
      logic am;
      logic amRise;
      logic bc;
      logic lr;
      logic din;
      logic refEvt;
      logic push;
      logic [32:0] word;
      logic [2:0] half;
      logic [15:0] target;
      usb = usbAttachedConfig;
      // External audio clock is refused in the USB-attached arrangement
      ext = externalClockMode && !usb; // [RULE_10]
      carry = 1'b0;
      am = 1'b0;
      amRise = 1'b0;
      bc = 1'b0;
      lr = 1'b0;
      din = 1'b0;
      push = 1'b0;
      word = 33'h0_0000_0000;
      half = rate48k ? voice_audio_pkg::BCLK48_HALF : voice_audio_pkg::BCLK16_HALF;
      target = usb ? voice_audio_pkg::REF_TICKS_USB :
         (rate48k ? voice_audio_pkg::REF_TICKS_48K : voice_audio_pkg::REF_TICKS_16K);
      refEvt = usb && usbStreamActive && usbRefTick; // [RULE_14]
      next_s = s;
      next_s.syncA = link.pin;
      next_s.syncB = s.syncA;
      next_s.micA = link.microphonePdmInputs;
      next_s.micB = s.micA;
      next_s.micStrobe = 1'b0;

      // Phase accumulator stands in for the loop oscillator
      {carry, next_s.nco} = {1'b0, s.nco} + {1'b0, s.ncoInc}; // [RULE_09]
      if (carry) begin
         next_s.amInt = !s.amInt;
      end
      am = ext ? s.syncB[voice_audio_pkg::PIN_AMCLK] : s.amInt;
      next_s.amPrev = am;
      amRise = am && !s.amPrev;

      if (amRise) begin
         next_s.refCnt = s.refCnt + 16'h0001;
         if (s.micDiv >= voice_audio_pkg::MIC_HALF - 2'h1) begin // [RULE_16]
            next_s.micDiv = 2'h0;
            next_s.micClk = !s.micClk; // [RULE_12]
            if (!s.micClk) begin
               next_s.micSample = s.micB;
               next_s.micStrobe = 1'b1;
            end
         end else begin
            next_s.micDiv = s.micDiv + 2'h1;
         end
         if (s.bclkDiv >= half - 3'h1) begin // [RULE_02]
            next_s.bclkDiv = 3'h0;
            next_s.bclkGen = !s.bclkGen;
            if (s.bclkGen) begin
               next_s.genCnt = (s.genCnt == 6'(voice_audio_pkg::FRAME_BITS - 1)) ?
                  6'h00 : s.genCnt + 6'h01;
               next_s.lrGen = (next_s.genCnt >= 6'(voice_audio_pkg::SLOT_BITS)); // [RULE_03]
            end
         end else begin
            next_s.bclkDiv = s.bclkDiv + 3'h1;
         end
      end

      // Master uses its own clocks; slave uses the synchronised pins
      bc = usb ? s.bclkGen : s.syncB[voice_audio_pkg::PIN_BCLK]; // [RULE_01] [RULE_07]
      lr = usb ? s.lrGen : s.syncB[voice_audio_pkg::PIN_FSC];
      din = usb ? s.syncB[voice_audio_pkg::PIN_L1] : s.syncB[voice_audio_pkg::PIN_L0]; // [RULE_08]
      next_s.bcPrev = bc;

      if (bc && !s.bcPrev) begin
         next_s.rxShift = {s.rxShift[30:0], din};
         // A frame edge seen here means this bit was the previous slot's last
         if (lr != s.lrLast) begin // [RULE_05]
            push = 1'b1;
            word = {s.lrLast, next_s.rxShift};
            next_s.fwdWord = next_s.rxShift;
            next_s.lrLast = lr;
            next_s.pos = 5'h00;
            if (!usb && lr) begin
               refEvt = 1'b1;
            end
         end else begin
            next_s.pos = (s.pos == 5'(voice_audio_pkg::SLOT_BITS - 1)) ? 5'h00 : s.pos + 5'h01;
         end
      end

      if (!bc && s.bcPrev) begin
         if (s.pos == 5'h00) begin // [RULE_04]
            // Underrun sends silence rather than repeating the last word
            next_s.txShift = s.txRdy ? 32'h0000_0000 : s.txHold;
            next_s.txRdy = 1'b1;
            next_s.fwdShift = s.fwdWord;
         end else begin
            next_s.txShift = {s.txShift[30:0], 1'b0};
            next_s.fwdShift = {s.fwdShift[30:0], 1'b0};
         end
      end
      if (s.txRdy && txValid) begin
         next_s.txHold = txData;
         next_s.txRdy = 1'b0;
      end

      // Frequency lock: count audio clock edges per reference period
      if (usb && !usbStreamActive) begin
         next_s.ncoInc = voice_audio_pkg::NCO_NOMINAL; // [RULE_15]
         next_s.refCnt = 16'h0000;
      end else if (refEvt) begin
         if (s.refCnt < target) begin
            next_s.ncoInc = s.ncoInc + voice_audio_pkg::NCO_TRIM_STEP; // [RULE_09]
         end else if (s.refCnt > target) begin
            next_s.ncoInc = s.ncoInc - voice_audio_pkg::NCO_TRIM_STEP; // [RULE_14]
         end
         next_s.refCnt = 16'h0000;
      end

      // Two-entry receive buffer; the serial side cannot wait, so a full buffer drops
      if (s.headV && rxReady) begin
         next_s.headV = s.spareV;
         next_s.head = s.spare;
         next_s.spareV = 1'b0;
      end
      if (push) begin
         if (!next_s.headV) begin
            next_s.headV = 1'b1;
            next_s.head = word;
         end else if (!next_s.spareV) begin
            next_s.spareV = 1'b1;
            next_s.spare = word;
         end else begin
            next_s.overrun = 1'b1;
         end
      end

      next_s.pinO = {next_s.txShift[31], next_s.txShift[31], next_s.lrGen, next_s.bclkGen,
         next_s.amInt};
      next_s.pinOeN[voice_audio_pkg::PIN_AMCLK] = ext; // [RULE_09]
      next_s.pinOeN[voice_audio_pkg::PIN_BCLK] = !usb; // [RULE_07]
      next_s.pinOeN[voice_audio_pkg::PIN_FSC] = !usb;
      next_s.pinOeN[voice_audio_pkg::PIN_L0] = !usb; // [RULE_06] [RULE_07]
      next_s.pinOeN[voice_audio_pkg::PIN_L1] = usb; // [RULE_06] [RULE_08]
      next_s.line2 = usb ? 1'b0 : next_s.fwdShift[31]; // [RULE_06]
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         s <= D_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign txReady = s.txRdy;
   assign rxData = s.head[31:0];
   assign rxRight = s.head[32];
   assign rxValid = s.headV;
   assign rxOverrun = s.overrun;
   assign micSample = s.micSample;
   assign micStrobe = s.micStrobe;
   assign link.devO = s.pinO;
   assign link.devOeN = s.pinOeN;
   assign link.serialAudioLine2 = s.line2;
   assign link.microphoneClockOut = s.micClk;
endmodule : voice_audio_device
`default_nettype wire

// >>> voice_audio_link_asserts.sv
`default_nettype none
module voice_audio_link_asserts (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Link signals
   input wire logic [4:0] pin,
   input wire logic [4:0] devOeN,
   input wire logic [4:0] hostOeN,
   input wire logic microphoneClockOut
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cur;
   logic [2:0] last;
   logic [2:0] seen;
   logic [7:0] cnt [3];
   logic [5:0] rises;
   logic lastFsc;
   logic fscSeen;
   assign cur = {microphoneClockOut, pin[1], pin[0]};
   // Half-period counts saturate so a stopped clock never wraps into the legal window
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         last <= 3'h0;
         seen <= 3'h0;
         cnt <= '{default: 8'h00};
         rises <= 6'h00;
         lastFsc <= 1'b0;
         fscSeen <= 1'b0;
      end else begin
         last <= cur;
         lastFsc <= pin[2];
         for (int i = 0; i < 3; i++) begin
            if (cur[i] != last[i]) begin
               cnt[i] <= 8'h01;
               seen[i] <= 1'b1;
            end else if (cnt[i] != 8'hFF) begin
               cnt[i] <= cnt[i] + 8'h01;
            end
         end
         if (pin[2] != lastFsc) begin
            rises <= 6'h00;
            fscSeen <= 1'b1;
         end else if (pin[1] && !last[1]) begin
            rises <= rises + 6'h01;
         end
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   amclk_half_a: assert property ((cur[0] != last[0] && seen[0]) |-> cnt[0] inside {[4:7]})
      else $error("audio clock half period out of range");
   bclk_half_a: assert property ((cur[1] != last[1] && seen[1]) |->
      (cnt[1] inside {[18:23]} || cnt[1] inside {[57:66]}))
      else $error("bit clock half period out of range");
   micclk_half_a: assert property ((cur[2] != last[2] && seen[2]) |-> cnt[2] inside {[18:23]})
      else $error("microphone clock half period out of range");
   slot_len_a: assert property (($changed(pin[2]) && fscSeen) |-> rises == 6'd32)
      else $error("slot length is not 32 bit clocks");
   fsc_edge_a: assert property ($changed(pin[2]) |-> !pin[1] && ($past(pin[1]) || $past(pin[1], 2)))
      else $error("frame select moved away from a bit clock fall");
   data_edge_a: assert property (($changed(pin[3]) && $stable(devOeN[3]) && $stable(hostOeN[3])) |->
      !pin[1] && ($past(pin[1]) || $past(pin[1], 2)))
      else $error("line 0 moved away from a bit clock fall");
   one_driver_a: assert property ((devOeN | hostOeN) == 5'h1F)
      else $error("two ends drive one pin");
   line0_master_a: assert property (!devOeN[3] |-> !devOeN[1] && !devOeN[2])
      else $error("line 0 driven without driving the clocks");
   line1_slave_a: assert property (!devOeN[4] |-> devOeN[1] && devOeN[2])
      else $error("line 1 driven while master");
   usb_amclk_a: assert property (!devOeN[1] |-> !devOeN[0])
      else $error("master mode without internal audio clock");
endmodule : voice_audio_link_asserts
`default_nettype wire

// >>> voice_audio_serial_clocking_test.sv
`default_nettype none
`define CHK(a, e) begin \
   numChecks++; \
   if ((a) !== (e)) begin \
      errorCnt++; \
      $display("CHECK FAILED at %0t: value mismatch", $time); \
   end \
end
module voice_audio_serial_clocking_test;
   timeunit 1ns;
   timeprecision 1ps;
   // Per mode: usbAttached, externalClock, rate48k, driveMasterClock
   // The last asks for an external clock, which the USB-attached arrangement must refuse
   localparam logic [3:0] MODES [4] = '{4'b0010, 4'b0101, 4'b1010, 4'b1100};
   logic mclk, resetn, usbCfg, extMode, rate48k, drvMclk, streamActive, refTick, rxReady, stall;
   logic [31:0] txD [2];
   logic [1:0] txV, lastR, lastNz;
   logic [3:0] micBits;
   logic [31:0] q [2][$];
   int left [2];
   int errorCnt, numChecks, micAge, tickCnt, waitCnt;
   integer seed;
   logic [31:0] lineWord;
   logic lineFs, lineBc;
   logic [31:0] fwdQ [$];
   wire [4:0] devOeN;
   wire [1:0] txR, rxV, rxR, take;
   wire [31:0] rxD [2];
   wire rxOverrun, micStrobe;
   wire [3:0] micSample;
   assign take = {rxV[1], rxV[0] & rxReady};
   voice_audio_link_if voice_audio_link_if_inst ();
   assign devOeN = voice_audio_link_if_inst.devOeN;
   voice_audio_device voice_audio_device_inst (
      .mclk(mclk), .resetn(resetn), .usbAttachedConfig(usbCfg), .externalClockMode(extMode),
      .rate48k(rate48k), .usbStreamActive(streamActive), .usbRefTick(refTick),
      .txData(txD[0]), .txValid(txV[0]), .txReady(txR[0]), .rxData(rxD[0]),
      .rxRight(rxR[0]), .rxValid(rxV[0]), .rxReady(rxReady), .rxOverrun(rxOverrun),
      .micSample(micSample), .micStrobe(micStrobe), .link(voice_audio_link_if_inst.device));
   voice_audio_host voice_audio_host_inst (
      .mclk(mclk), .resetn(resetn), .usbAttachedConfig(usbCfg), .rate48k(rate48k),
      .driveMasterClock(drvMclk), .sendReference(usbCfg), .txData(txD[1]), .txValid(txV[1]),
      .txReady(txR[1]), .rxData(rxD[1]), .rxRight(rxR[1]), .rxValid(rxV[1]),
      .micBits(micBits), .link(voice_audio_link_if_inst.host));
   voice_audio_link_asserts voice_audio_link_asserts_inst (
      .mclk(mclk), .resetn(resetn), .pin(voice_audio_link_if_inst.pin),
      .devOeN(voice_audio_link_if_inst.devOeN), .hostOeN(voice_audio_link_if_inst.hostOeN),
      .microphoneClockOut(voice_audio_link_if_inst.microphoneClockOut));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task printVerdict;
      if (errorCnt == 0 && numChecks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : printVerdict
   task automatic waitFrames(input int n);
      int k;
      int t;
      logic prev;
      k = 0;
      t = 0;
      prev = voice_audio_link_if_inst.pin[2];
      while (k < n && t < 20000 * n) begin
         @(posedge mclk);
         t++;
         if (voice_audio_link_if_inst.pin[2] && !prev) k++;
         prev = voice_audio_link_if_inst.pin[2];
      end
      `CHK(k, n)
   endtask : waitFrames
   function automatic int pendingWords();
      return left[0] + left[1] + q[0].size() + q[1].size() + fwdQ.size();
   endfunction : pendingWords
   // Each end streams words; bit 0 is forced so empty slots, which carry zero, are told apart
   always @(posedge mclk) begin
      for (int i = 0; i < 2; i++) begin
         if (txV[i] && txR[i]) begin
            q[1 - i].push_back(txD[i]);
            if (i == 1 && !usbCfg) fwdQ.push_back(txD[i]);
            left[i]--;
            txD[i] <= $random(seed) | 32'h1;
            txV[i] <= left[i] > 0;
         end else if (left[i] > 0 && !txV[i]) begin
            txV[i] <= 1'b1;
            txD[i] <= $random(seed) | 32'h1;
         end
      end
   end
   always @(posedge mclk) begin
      for (int i = 0; i < 2; i++) begin
         if (resetn && take[i] && rxD[i] !== 32'h0) begin
            if (lastNz[i]) `CHK(rxR[i], ~lastR[i])
            `CHK(rxD[i], q[i].size() > 0 ? q[i].pop_front() : 32'hX)
            lastR[i] = rxR[i];
            lastNz[i] = 1'b1;
         end else if (take[i]) begin
            lastNz[i] = 1'b0;
         end
      end
   end
   always @(posedge mclk) begin
      // Restart after reset: captures made before the model saw a clock fall are not judged
      micAge <= resetn ? micAge + 1 : 0;
      if (micAge == 300) begin
         micBits <= 4'($random(seed));
         micAge <= 0;
      end
      if (micStrobe && micAge > 100) `CHK(micSample, micBits)
      tickCnt <= (tickCnt == 3999) ? 0 : tickCnt + 1;
      refTick <= tickCnt == 3999;
      rxReady <= stall ? 1'b0 : 1'($random(seed));
   end
   // Line 2 is read at the bit-clock rises on the pins, as a DAC would read it
   always @(posedge mclk) begin
      if (!resetn) begin
         lineWord = 32'h0;
         lineFs = 1'b0;
      end else if (voice_audio_link_if_inst.pin[1] && !lineBc) begin
         lineWord = {lineWord[30:0], voice_audio_link_if_inst.serialAudioLine2};
         if (voice_audio_link_if_inst.pin[2] != lineFs) begin
            if (usbCfg) begin
               `CHK(lineWord, 32'h0)
            end else if (lineWord !== 32'h0) begin
               `CHK(lineWord, fwdQ.size() > 0 ? fwdQ.pop_front() : 32'hX)
            end
            lineFs = voice_audio_link_if_inst.pin[2];
         end
      end
      lineBc = voice_audio_link_if_inst.pin[1];
   end
   initial begin
      resetn = 1'b0;
      {usbCfg, extMode, rate48k, drvMclk} = 4'h0;
      {streamActive, refTick, rxReady, stall} = 4'h0;
      txD = '{32'h0, 32'h0};
      txV = 2'b00;
      left = '{0, 0};
      lastNz = 2'b00;
      micBits = 4'h0;
      {micAge, tickCnt, errorCnt, numChecks} = {32'h0, 32'h0, 32'h0, 32'h0};
      seed = 32'h265A;
      for (int m = 0; m < 4; m++) begin
         resetn <= 1'b0;
         {usbCfg, extMode, rate48k, drvMclk} <= MODES[m];
         streamActive <= 1'b0;
         repeat (8) @(posedge mclk);
         resetn <= 1'b1;
         @(posedge mclk);
         #1;
         `CHK(txR, 2'b11)
         `CHK(rxOverrun, 1'b0)
         waitFrames(2);
         streamActive <= usbCfg;
         lastNz = 2'b00;
         left = '{4, 4};
         waitCnt = 0;
         while (pendingWords() > 0 && waitCnt < 40000) begin
            @(posedge mclk);
            waitCnt++;
         end
         `CHK(pendingWords(), 0)
         `CHK(devOeN, {usbCfg ? 4'b1000 : 4'b0111, extMode && !usbCfg})
         if (m == 0) begin
            // Empty slots still deliver words, so a held-off reader must overflow
            stall <= 1'b1;
            waitFrames(2);
            `CHK(rxOverrun, 1'b1)
            stall <= 1'b0;
         end
      end
      printVerdict();
   end
   initial begin
      repeat (100000) @(posedge mclk);
      errorCnt++;
      printVerdict();
   end
endmodule : voice_audio_serial_clocking_test
`default_nettype wire
